// ---- hw/sfp_fifo.v ----
// Small valid/ready FIFO for committed write bytes
`timescale 1ns/1ps
module sfp_fifo #(
	parameter W = 25,
	parameter D = 4,
	parameter AW = 2
) (
	input wire mclk,
	input wire nrst,
	input wire inValid,
	output wire inReady,
	input wire [W-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [W-1:0] outData
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	// Honest full and empty from the fill count
	assign inReady = (count_q != D[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_q];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// Storage
	always @(posedge mclk)
	begin
		if (push)
			mem[wrPtr_q] <= inData;
	end

	// Pointers and count
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wrPtr_q <= (wrPtr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= (rdPtr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // sfp_fifo

// ---- hw/sfp_fram.v ----
// SPI F-RAM slave: status register, write protection and array access
//
// Behaviour
// - Status: bit7 pin-protect enable, bits3:2 block guard, bit1 latch; 6=1, 0/4/5=0.
// - Write latch flag shows writes permitted; zero after power-up.
// - Status write never changes the latch; only set, clear and auto-clear do.
// - Block guard bits are nonvolatile and survive reset.
// - Guard 00 none, 01 18000h-1FFFFh, 10 10000h-1FFFFh, 11 whole array.
// - Array writes gated only by latch and block guard, never the protect pin.
// - Pin-protect enable set and pin low rejects status writes; else latch decides.
// - A status write clears the latch when it completes.
// - Read status returns exactly one byte of current status.
// - Status write updates only pin-protect enable and block guard bits.
// - Write: opcode, three address bytes holding 17 bits, data, all MSB first.
// - Burst address advances per byte and wraps 1FFFFh to 00000h.
// - Each byte committed after its eighth bit, no busy time, no burst limit.
// - Burst hitting a guarded address stops incrementing and drops later bytes.
// - Chip select rising ends a memory write.
// - Read drives data on next eight clocks MSB first, ignores input, continues.
// - Chip select rising ends a read and floats the output.
// - Fast read adds one dummy byte after the address, otherwise like read.
// - Opcodes 06 set, 04 clear, 05 read status, 01 write status, 03 read, 02 write.
// - Latch cleared at chip select rising after clear, status write or write.
// - Sample input on rising clock, change output on falling; modes 0 and 3.
// - Unknown opcode ignored until next chip select fall, output stays floating.
`timescale 1ns/1ps
`include "sfp_consts.vh"
module sfp_fram (
	input wire mclk,
	input wire nrst,
	input wire csN,
	input wire sclk,
	input wire si,
	input wire wpN,
	output reg soData_q,
	output reg soOe_q
);
	localparam ST_IDLE = 3'h0;
	localparam ST_OP = 3'h1;
	localparam ST_ADDR = 3'h2;
	localparam ST_DUMMY = 3'h3;
	localparam ST_RDDATA = 3'h4;
	localparam ST_SRDATA = 3'h5;
	localparam ST_SRWR = 3'h6;
	localparam ST_WRDATA = 3'h7;

	reg [1:0] csS_q;
	reg [1:0] sckS_q;
	reg [1:0] siS_q;
	reg [1:0] wpS_q;
	reg sckPrev_q;
	reg csPrev_q;
	reg [2:0] state_q;
	reg [2:0] bitCnt_q;
	reg [1:0] byteCnt_q;
	reg [6:0] rxByte_q;
	reg [7:0] op_q;
	reg [16:0] addr_q;
	reg [7:0] txShift_q;
	reg writeLatchFlag_q;
	reg wrStop_q;
	reg fetch_q;
	reg loadTx_q;
	reg wrPend_q;
	reg [24:0] wrEntry_q;
	reg nvWr_q;
	reg [2:0] nvData_q;
	reg [7:0] memRd_q;
	reg protectPinEnable_q = `SFP_PROTECT_PIN_ENABLE_INIT;
	reg [1:0] blockGuard_q = `SFP_GUARD_INIT;
	reg [7:0] mem [0:`SFP_MEM_DEPTH-1];
	wire csLow;
	wire sckRise;
	wire sckFall;
	wire csFall;
	wire csRise;
	wire siBit;
	wire [7:0] rxFull;
	wire [7:0] statusByte;
	wire addrGuarded;
	wire srWriteOk;
	wire txOn;
	wire fifoInReady;
	wire fifoOutValid;
	wire [24:0] fifoOut;
	wire drainReady;

	// Two-stage synchronisers on every pin
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			csS_q <= 2'h3;
			sckS_q <= 2'h0;
			siS_q <= 2'h0;
			wpS_q <= 2'h3;
			sckPrev_q <= 1'b0;
			csPrev_q <= 1'b1;
		end
		else
		begin
			csS_q <= {csS_q[0], csN};
			sckS_q <= {sckS_q[0], sclk};
			siS_q <= {siS_q[0], si};
			wpS_q <= {wpS_q[0], wpN};
			sckPrev_q <= sckS_q[1];
			csPrev_q <= csS_q[1];
		end
	end

	// Edge detection; no idle level is captured, both modes use the same edges
	assign csLow = ~csS_q[1];
	assign csFall = csLow & csPrev_q;
	assign csRise = csS_q[1] & ~csPrev_q;
	assign sckRise = csLow & ~csFall & sckS_q[1] & ~sckPrev_q;
	assign sckFall = csLow & ~sckS_q[1] & sckPrev_q;
	assign siBit = siS_q[1];
	assign rxFull = {rxByte_q, siBit};

	// Status byte with fixed bits
	assign statusByte = `SFP_SR_FIXED | {protectPinEnable_q, 3'h0, blockGuard_q, writeLatchFlag_q, 1'b0};

	// Guarded range decode
	assign addrGuarded = (blockGuard_q == `SFP_BG_ALL) ||
		(blockGuard_q == `SFP_BG_HALF && addr_q[`SFP_ADDR_HALF]) ||
		(blockGuard_q == `SFP_BG_QTR && addr_q[`SFP_ADDR_HALF] && addr_q[`SFP_ADDR_QTR]);

	// Status write permission, the pin only matters when enabled
	assign srWriteOk = writeLatchFlag_q & ~(protectPinEnable_q & ~wpS_q[1]);
	assign txOn = (state_q == ST_RDDATA) || (state_q == ST_SRDATA);

	// Array port: read fetch has priority, writes drain otherwise
	assign drainReady = ~fetch_q;

	// Command sequencer
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
			bitCnt_q <= 3'h0;
			byteCnt_q <= 2'h0;
			rxByte_q <= 7'h00;
			op_q <= `SFP_OP_NONE;
			addr_q <= 17'h00000;
			txShift_q <= 8'h00;
			writeLatchFlag_q <= 1'b0;
			wrStop_q <= 1'b0;
			fetch_q <= 1'b0;
			loadTx_q <= 1'b0;
			wrPend_q <= 1'b0;
			wrEntry_q <= 25'h0000000;
			nvWr_q <= 1'b0;
			nvData_q <= 3'h0;
			soData_q <= 1'b0;
			soOe_q <= 1'b0;
		end
		else
		begin
			fetch_q <= 1'b0;
			nvWr_q <= 1'b0;
			loadTx_q <= fetch_q;
			if (wrPend_q && fifoInReady)
				wrPend_q <= 1'b0;
			if (csRise)
			begin
				state_q <= ST_IDLE;
				soOe_q <= 1'b0;
				if (op_q == `SFP_OP_CLRWL || op_q == `SFP_OP_WRITE_STATUS_CMD || op_q == `SFP_OP_WRITE)
					writeLatchFlag_q <= 1'b0;
			end
			else if (csFall)
			begin
				state_q <= ST_OP;
				bitCnt_q <= 3'h0;
				byteCnt_q <= 2'h0;
				op_q <= `SFP_OP_NONE;
				wrStop_q <= 1'b0;
			end
			else if (sckRise && state_q != ST_IDLE)
			begin
				rxByte_q <= rxFull[6:0];
				bitCnt_q <= bitCnt_q + 1'b1;
				if (state_q == ST_ADDR)
					addr_q <= {addr_q[15:0], siBit};
				if (bitCnt_q == `SFP_BIT_LAST)
				begin
					case (state_q)
						ST_OP:
						begin
							op_q <= rxFull;
							case (rxFull)
								`SFP_OP_SETWL:
								begin
									writeLatchFlag_q <= 1'b1;
									state_q <= ST_IDLE;
								end
								`SFP_OP_READ_STATUS_CMD:
								begin
									txShift_q <= statusByte;
									state_q <= ST_SRDATA;
								end
								`SFP_OP_WRITE_STATUS_CMD:
									state_q <= ST_SRWR;
								`SFP_OP_READ, `SFP_OP_FAST, `SFP_OP_WRITE:
									state_q <= ST_ADDR;
								default:
									state_q <= ST_IDLE;
							endcase
						end
						ST_ADDR:
						begin
							byteCnt_q <= byteCnt_q + 1'b1;
							if (byteCnt_q == `SFP_ADDR_LAST)
							begin
								if (op_q == `SFP_OP_FAST)
									state_q <= ST_DUMMY;
								else if (op_q == `SFP_OP_READ)
								begin
									state_q <= ST_RDDATA;
									fetch_q <= 1'b1;
								end
								else
									state_q <= ST_WRDATA;
							end
						end
						ST_DUMMY:
						begin
							state_q <= ST_RDDATA;
							fetch_q <= 1'b1;
						end
						ST_RDDATA:
							fetch_q <= 1'b1;
						ST_SRDATA:
							state_q <= ST_IDLE;
						ST_SRWR:
						begin
							if (srWriteOk)
							begin
								nvWr_q <= 1'b1;
								nvData_q <= {rxFull[`SFP_SR_PROTECT_PIN_ENABLE], rxFull[`SFP_SR_BG_HI], rxFull[`SFP_SR_BG_LO]};
							end
							state_q <= ST_IDLE;
						end
						ST_WRDATA:
						begin
							if (!wrStop_q)
							begin
								if (addrGuarded)
									wrStop_q <= 1'b1;
								else
								begin
									if (writeLatchFlag_q)
									begin
										wrPend_q <= 1'b1;
										wrEntry_q <= {addr_q, rxFull};
									end
									addr_q <= addr_q + `SFP_ADDR_ONE;
								end
							end
						end
						default:
							state_q <= ST_IDLE;
					endcase
				end
			end
			// Output shifts on falling clock only
			if (sckFall)
			begin
				soOe_q <= txOn;
				soData_q <= txShift_q[7];
				txShift_q <= {txShift_q[6:0], 1'b0};
			end
			// Fetched byte loads the shifter, then the address moves on
			if (loadTx_q)
			begin
				txShift_q <= memRd_q;
				addr_q <= addr_q + `SFP_ADDR_ONE;
			end
		end
	end

	// Nonvolatile bits: factory value at power-up, untouched by reset, one driver only
	always @(posedge mclk)
	begin
		if (nvWr_q)
		begin
			protectPinEnable_q <= nvData_q[2];
			blockGuard_q <= nvData_q[1:0];
		end
	end

	// Array: one port shared by read fetch and write drain
	always @(posedge mclk)
	begin
		if (fetch_q)
			memRd_q <= mem[addr_q];
		else if (fifoOutValid)
			mem[fifoOut[`SFP_FIFO_W-1:`SFP_DATA_W]] <= fifoOut[`SFP_DATA_W-1:0];
	end

	// Committed bytes queue toward the array
	sfp_fifo #(
		.W(`SFP_FIFO_W),
		.D(`SFP_FIFO_D),
		.AW(`SFP_FIFO_AW)
	) uWrFifo (
		.mclk(mclk),
		.nrst(nrst),
		.inValid(wrPend_q),
		.inReady(fifoInReady),
		.inData(wrEntry_q),
		.outValid(fifoOutValid),
		.outReady(drainReady),
		.outData(fifoOut)
	);
endmodule // sfp_fram

// ---- inc/sfp_consts.vh ----
// Constants for the serial F-RAM protect and access block
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH
// Opcodes
`define SFP_OP_SETWL 8'h06
`define SFP_OP_CLRWL 8'h04
`define SFP_OP_READ_STATUS_CMD 8'h05
`define SFP_OP_WRITE_STATUS_CMD 8'h01
`define SFP_OP_READ 8'h03
`define SFP_OP_FAST 8'h0B
`define SFP_OP_WRITE 8'h02
`define SFP_OP_NONE 8'h00
// Array geometry
`define SFP_ADDR_W 17
`define SFP_MEM_DEPTH 131072
`define SFP_ADDR_ONE 17'h00001
// Address bits that mark the upper half and the upper quarter
`define SFP_ADDR_HALF 16
`define SFP_ADDR_QTR 15
// Data byte width inside a write FIFO entry
`define SFP_DATA_W 8
// Status byte: fixed bit 6 high, bits 0, 4, 5 low
`define SFP_SR_FIXED 8'h40
`define SFP_SR_PROTECT_PIN_ENABLE 7
`define SFP_SR_BG_HI 3
`define SFP_SR_BG_LO 2
// Factory values of the nonvolatile bits
`define SFP_GUARD_INIT 2'h0
`define SFP_PROTECT_PIN_ENABLE_INIT 1'h0
// Block guard encodings
`define SFP_BG_QTR 2'h1
`define SFP_BG_HALF 2'h2
`define SFP_BG_ALL 2'h3
// Bit and byte counts
`define SFP_BIT_LAST 3'h7
`define SFP_ADDR_LAST 2'h2
// Write FIFO: address plus data
`define SFP_FIFO_W 25
`define SFP_FIFO_D 4
`define SFP_FIFO_AW 2
`endif

// ---- verification/sfp_fram_chk.sv ----
// Port-level assertions for the SPI F-RAM block
`timescale 1ns/1ps
module sfp_fram_chk (
	input wire mclk,
	input wire nrst,
	input wire csN,
	input wire sclk,
	input wire si,
	input wire wpN,
	input wire soData_q,
	input wire soOe_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// Deselected long enough for the output to float
	sequence csIdle;
		csN [*7];
	endsequence
	// No output in the first eight clocks after select falls
	sequence opQuiet;
		!soOe_q [*8];
	endsequence
	a_rst_float: assert property ($rose(nrst) |-> !soOe_q && !soData_q)
		else $error("output active right after reset");
	a_idle_float: assert property (csIdle |-> !soOe_q)
		else $error("output driven while deselected");
	a_oe_selected: assert property ($rose(soOe_q) |-> !csN && !$past(csN))
		else $error("output enabled without select");
	a_rise_float: assert property ($rose(csN) |-> ##[1:6] !soOe_q)
		else $error("output not released after select rise");
	a_opcode_quiet: assert property ($fell(csN) |-> opQuiet)
		else $error("output driven during opcode");
	a_bit_hold: assert property (soOe_q && $past(soOe_q) && $changed(soData_q) |-> !$past(sclk, 3))
		else $error("output bit changed away from falling clock");
	a_oe_on_fall: assert property ($rose(soOe_q) |-> !$past(sclk, 3))
		else $error("output enabled away from falling clock");
	a_oe_stands: assert property ($rose(soOe_q) |-> soOe_q [*6])
		else $error("output enable too short");
endmodule // sfp_fram_chk

bind sfp_fram sfp_fram_chk chk_u (.mclk(mclk), .nrst(nrst), .csN(csN), .sclk(sclk), .si(si),
	.wpN(wpN), .soData_q(soData_q), .soOe_q(soOe_q));

// ---- verification/sfp_spi_host.sv ----
// SPI host model: drives select, clock and data, samples the serial output
`timescale 1ns/1ps
module sfp_spi_host (
	input wire mclk,
	input wire soLine,
	output reg csN = 1'b1,
	output reg sclk = 1'b0,
	output reg si = 1'b0,
	output reg rxStb = 1'b0,
	output reg [7:0] rxByte = 8'h00
);
	reg idleLvl = 1'b0;
	// Park clock at the mode's idle level, then select
	task open_sel(input m);
		begin
			idleLvl = m;
			@(posedge mclk);
			sclk <= m;
			repeat (4) @(posedge mclk);
			csN <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask
	// One byte MSB first; output sampled late in the high phase
	task xbyte(input [7:0] tx, input chk);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
			begin
				@(posedge mclk);
				sclk <= 1'b0;
				si <= tx[i];
				repeat (4) @(posedge mclk);
				sclk <= 1'b1;
				repeat (3) @(posedge mclk);
				rxByte[i] = soLine;
			end
			rxStb <= chk;
			@(posedge mclk);
			rxStb <= 1'b0;
		end
	endtask
	// Return clock to idle and deselect
	task close_sel;
		begin
			@(posedge mclk);
			sclk <= idleLvl;
			repeat (4) @(posedge mclk);
			csN <= 1'b1;
			repeat (8) @(posedge mclk);
		end
	endtask
endmodule // sfp_spi_host

// ---- verification/tb.sv ----
// Bench for the SPI F-RAM block: host drives, scoreboard checks read bytes
`timescale 1ns/1ps
module tb;
	reg mclk = 1'b0;
	reg nrst = 1'b0;
	reg wpN = 1'b1;
	reg flip = 1'b0;
	wire csN, sclk, si, soData_q, soOe_q, rxStb, soLine;
	wire [7:0] rxByte;
	integer n_fail = 0;
	integer cmp_count = 0;
	integer i;
	reg [7:0] e;
	reg [7:0] d [0:7];
	reg [7:0] expQ [$];
	// Clock, and a changing level on the floating output line
	always #10 mclk = ~mclk;
	always @(posedge mclk) flip <= ~flip;
	assign soLine = soOe_q ? soData_q : flip;
	sfp_fram dut_u (.mclk(mclk), .nrst(nrst), .csN(csN), .sclk(sclk), .si(si), .wpN(wpN),
		.soData_q(soData_q), .soOe_q(soOe_q));
	sfp_spi_host host_u (.mclk(mclk), .soLine(soLine), .csN(csN), .sclk(sclk), .si(si),
		.rxStb(rxStb), .rxByte(rxByte));
	// Scoreboard: oldest note against each received byte
	always @(posedge mclk)
		if (rxStb === 1'b1)
		begin
			e = expQ.pop_front();
			cmp_count = cmp_count + 1;
			if (rxByte !== e)
			begin
				n_fail = n_fail + 1;
				$display("BAD %0t got %h exp %h", $time, rxByte, e);
			end
		end
	// Select in a random mode, send opcode and optional address
	task cmd(input [7:0] op, input [23:0] adr, input integer na);
		integer k;
		begin
			host_u.open_sel(($urandom % 2) == 1);
			host_u.xbyte(op, 1'b0);
			for (k = 2; k >= 3 - na; k = k - 1)
				host_u.xbyte(adr[k*8 +: 8], 1'b0);
		end
	endtask
	task put(input [7:0] b);
		host_u.xbyte(b, 1'b0);
	endtask
	// Note the expected byte; random input meanwhile
	task get(input [7:0] x);
		begin
			expQ.push_back(x);
			host_u.xbyte(8'($urandom), 1'b1);
		end
	endtask
	task op_only(input [7:0] op);
		begin
			cmd(op, 24'h0, 0);
			host_u.close_sel();
		end
	endtask
	task wr_status(input [7:0] v);
		begin
			op_only(8'h06);
			cmd(8'h01, 24'h0, 0);
			put(v);
			host_u.close_sel();
		end
	endtask
	task rd_status(input [7:0] x);
		begin
			cmd(8'h05, 24'h0, 0);
			get(x);
			host_u.close_sel();
		end
	endtask
	task wr_mem(input we, input [23:0] a, input integer s, input integer n);
		integer k;
		begin
			if (we)
				op_only(8'h06);
			cmd(8'h02, a, 3);
			for (k = s; k < s + n; k = k + 1)
				put(d[k]);
			host_u.close_sel();
		end
	endtask
	task rd_mem(input [7:0] op, input [23:0] a, input integer s0, input integer s1);
		begin
			cmd(op, a, 3);
			if (op == 8'h0B)
				put(8'($urandom));
			get(d[s0]);
			if (s1 >= 0)
				get(d[s1]);
			host_u.close_sel();
		end
	endtask
	task final_report;
		begin
			$display("fails %0d compares %0d", n_fail, cmp_count);
			if (n_fail == 0 && cmp_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Watchdog
	initial
	begin
		#1000000;
		n_fail = n_fail + 1;
		final_report;
	end
	// Main sequence
	initial
	begin
		i = $urandom(32'hCB18D135);
		for (i = 0; i < 8; i = i + 1)
			d[i] = 8'($urandom);
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		rd_status(8'h40);
		op_only(8'h06);
		rd_status(8'h42);
		op_only(8'h04);
		rd_status(8'h40);
		wr_mem(1'b1, 24'h01FFFF, 0, 2);
		wr_mem(1'b1, 24'h017FFF, 2, 2);
		wr_mem(1'b0, 24'h000000, 4, 1);
		rd_mem(8'h03, 24'h01FFFF, 0, 1);
		rd_mem(8'h0B, 24'h017FFF, 2, 3);
		wr_status(8'h87);
		rd_status(8'hC4);
		wpN <= 1'b0;
		wr_status(8'h00);
		rd_status(8'hC4);
		wr_mem(1'b1, 24'h017FFF, 5, 3);
		rd_mem(8'h03, 24'h017FFF, 5, 3);
		op_only(8'h06);
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		rd_status(8'hC4);
		wpN <= 1'b1;
		// Unknown opcode, then a set-latch byte that must be ignored
		cmd(8'hFF, 24'h060000, 1);
		host_u.close_sel();
		rd_status(8'hC4);
		for (i = 2; i < 4; i = i + 1)
		begin
			// Pin low on the second pass, while the pin-protect enable is clear
			wpN <= (i == 2);
			wr_status(8'(i * 4));
			rd_status(8'(i * 4 + 64));
			wr_mem(1'b1, (i == 2) ? 24'h017FFF : 24'h0, 0, 1);
			rd_mem(8'h03, (i == 2) ? 24'h017FFF : 24'h0, (i == 2) ? 5 : 1, -1);
		end
		final_report;
	end
endmodule // tb
